// ===== core/ots_defs.svh
// offsets, reset values and timing counts of the output terminal selector
`ifndef OTS_DEFS_SVH
`define OTS_DEFS_SVH
`define OTS_CLK_MHZ 50
`define OTS_POR_TIME_US 1000
`define OTS_POR_CYCLES (`OTS_POR_TIME_US * `OTS_CLK_MHZ)
`define OTS_NEG_BASE 8'h64
`define OTS_CODE_LIMIT 8'hC8
`define OTS_CODE_PULSE 7'h5D
`define OTS_PCT_WARN 7'h55
`define OTS_PCT_FULL 7'h64
`define OTS_SAME_AS_FWD 16'h270F
`define OTS_OFF_SEL0 8'h00
`define OTS_OFF_SEL1 8'h04
`define OTS_OFF_SEL2 8'h08
`define OTS_OFF_SENS 8'h0C
`define OTS_OFF_FU_FWD 8'h10
`define OTS_OFF_FU_REV 8'h14
`define OTS_OFF_OC_LVL 8'h18
`define OTS_OFF_OC_TIME 8'h1C
`define OTS_OFF_ZC_LVL 8'h20
`define OTS_OFF_ZC_TIME 8'h24
`define OTS_OFF_REGEN 8'h28
`define OTS_OFF_THERM 8'h2C
`define OTS_OFF_HEAT 8'h30
`define OTS_OFF_MAINT 8'h34
`define OTS_OFF_REMOTE 8'h38
`define OTS_OFF_START 8'h3C
`define OTS_OFF_CTRL 8'h40
`define OTS_OFF_STATUS 8'h44
`define OTS_RST_SEL0 8'h00
`define OTS_RST_SEL1 8'h04
`define OTS_RST_SEL2 8'h63
`define OTS_RST_SENS 7'h0A
`define OTS_RST_FU_FWD 16'h0258
`define OTS_RST_START 16'h0032
`define OTS_RST_LEVEL 16'hFFFF
`define OTS_RST_TIME 16'h0000
`define OTS_RESP_OKAY 2'h0
`define OTS_RESP_SLVERR 2'h2
`endif

// ===== core/ots_pkg.sv
// types shared by the output terminal selector
package ots_pkg;
  typedef logic [7:0] ots_code_t;
  typedef logic [15:0] ots_word_t;
  typedef enum logic [6:0] {
    OTS_C_ACTIVE = 7'h00, OTS_C_SPEED = 7'h01, OTS_C_OVERLOAD = 7'h03,
    OTS_C_FREQ = 7'h04, OTS_C_REGEN = 7'h07, OTS_C_THERMAL = 7'h08,
    OTS_C_READY = 7'h0B, OTS_C_OVERCUR = 7'h0C, OTS_C_ZEROCUR = 7'h0D,
    OTS_C_FB_LOW = 7'h0E, OTS_C_FB_HIGH = 7'h0F, OTS_C_PID_FWD = 7'h10,
    OTS_C_BRAKE = 7'h14, OTS_C_FAN = 7'h19, OTS_C_HEAT = 7'h1A,
    OTS_C_PLOSS = 7'h2E, OTS_C_PID_ON = 7'h2F, OTS_C_RETRY = 7'h40,
    OTS_C_WEAR = 7'h5A, OTS_C_HWFAULT = 7'h5B, OTS_C_PULSE = 7'h5D,
    OTS_C_MAINT = 7'h5F, OTS_C_REMOTE = 7'h60, OTS_C_MINOR = 7'h62,
    OTS_C_TRIP = 7'h63
  } ots_cond_t;
endpackage : ots_pkg

// ===== core/ots_select.sv
// output terminal function selector with axi4-lite register access
`timescale 1ns/10ps
`default_nettype none
`include "ots_defs.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// - codes 0-99 give condition true-high; 100-199 same condition inverted
// - code 0/100: running with output frequency at or above start freq
// - code 1/101: output frequency within sensitivity band of set freq
// - code 3/103: high while stall prevention is active
// - code 4/104: frequency reached threshold, reverse threshold if set
// - code 7/107: regen duty at 85 percent of permitted duty
// - code 8/108: thermal at 85 percent; trip at 100 percent
// - code 11/111: ready after power-on reset, while start possible
// - code 12/112: current above level longer than detection time
// - code 13/113: current below level longer than detection time
// - codes 14/114, 15/115: feedback below low or above high limit
// - code 20/120: brake open request when brake sequence enabled
// - code 25/125: cooling fan fault
// - code 26/126: heatsink at about 85 percent of overheat level
// - code 46/146: power-failure deceleration running
// - code 90/190: any part nearing end of service life
// - code 91/191: internal circuit failure or wiring mistake fault
// - code 93/193: current and maintenance count pulse train; refused on relay
// - code 95/195: maintenance count at or above alarm threshold
// - code 96/196: terminal follows software remote output bit
// - code 98/198: fan failure or communication warning
// - code 99/199: trip held until fault reset
module ots_select #(
  parameter int NUM_TERM = 3,
  parameter int RELAY_IDX = 2,
  parameter int POR_CYCLES = `OTS_POR_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic running,
  input wire logic reverse,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] out_current,
  input wire logic [15:0] avg_current,
  input wire logic stall_active,
  input wire logic [15:0] regen_duty,
  input wire logic [15:0] thermal_acc,
  input wire logic [15:0] heatsink_temp,
  input wire logic fb_below_low,
  input wire logic fb_above_high,
  input wire logic pid_forward,
  input wire logic pid_active,
  input wire logic retry_active,
  input wire logic brake_seq_en,
  input wire logic brake_open,
  input wire logic fan_fault,
  input wire logic powerloss_decel,
  input wire logic [3:0] life_near_end,
  input wire logic hw_fault,
  input wire logic comm_warning,
  input wire logic fault_event,
  input wire logic [15:0] maint_count,
  output logic [NUM_TERM-1:0] term_out,
  output logic thermal_trip
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  ots_pkg::ots_code_t sel [NUM_TERM];
  logic [6:0] sens;
  ots_pkg::ots_word_t fu_fwd, fu_rev, oc_lvl, oc_time, zc_lvl, zc_time;
  ots_pkg::ots_word_t regen_lim, therm_lim, heat_lim, maint_lim, start_freq;
  logic [NUM_TERM-1:0] remote;
  logic fault_clr;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] new_val, upd_val;

  // decoded condition codes
  function automatic logic code_known(input logic [6:0] b);
    case (b)
      7'h00, 7'h01, 7'h03, 7'h04, 7'h07, 7'h08, 7'h0B, 7'h0C, 7'h0D,
      7'h0E, 7'h0F, 7'h10, 7'h14, 7'h19, 7'h1A, 7'h2E, 7'h2F, 7'h40,
      7'h5A, 7'h5B, 7'h5D, 7'h5F, 7'h60, 7'h62, 7'h63: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction : code_known

  function automatic logic [6:0] code_base(input logic [7:0] c);
    if (c >= `OTS_NEG_BASE) begin
      code_base = 7'(c - `OTS_NEG_BASE);
    end else begin
      code_base = c[6:0];
    end
  endfunction : code_base

  function automatic logic code_ok(input logic [7:0] c, input logic relay);
    code_ok = (c < `OTS_CODE_LIMIT) && code_known(code_base(c))
      && !(relay && code_base(c) == `OTS_CODE_PULSE);
  endfunction : code_ok

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OTS_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp(aw_addr, new_val);
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign new_val = merge(32'h00000000, w_data, w_strb);
  assign upd_val = merge(rd_word(aw_addr), w_data, w_strb);
  // unmapped, read-only or refused selection writes answer slverr
  function automatic logic [1:0] wr_resp(input logic [7:0] a,
                                         input logic [31:0] v);
    case (a)
      `OTS_OFF_SEL0: wr_resp = code_ok(v[7:0], RELAY_IDX == 0)
        ? `OTS_RESP_OKAY : `OTS_RESP_SLVERR;
      `OTS_OFF_SEL1: wr_resp = code_ok(v[7:0], RELAY_IDX == 1)
        ? `OTS_RESP_OKAY : `OTS_RESP_SLVERR;
      `OTS_OFF_SEL2: wr_resp = code_ok(v[7:0], RELAY_IDX == 2)
        ? `OTS_RESP_OKAY : `OTS_RESP_SLVERR;
      `OTS_OFF_SENS, `OTS_OFF_FU_FWD, `OTS_OFF_FU_REV, `OTS_OFF_OC_LVL,
      `OTS_OFF_OC_TIME, `OTS_OFF_ZC_LVL, `OTS_OFF_ZC_TIME, `OTS_OFF_REGEN,
      `OTS_OFF_THERM, `OTS_OFF_HEAT, `OTS_OFF_MAINT, `OTS_OFF_REMOTE,
      `OTS_OFF_START, `OTS_OFF_CTRL: wr_resp = `OTS_RESP_OKAY;
      default: wr_resp = `OTS_RESP_SLVERR;
    endcase
  endfunction : wr_resp

  ////////////////////////////////////////////////////////////////////////////
  // register writes; a refused selection code keeps the old one
  genvar t;
  generate
    for (t = 0; t < NUM_TERM; t++) begin : g_sel
      localparam logic [7:0] OFF = 8'(t * 4);
      localparam ots_pkg::ots_code_t RST = (t == 0) ? `OTS_RST_SEL0 :
        (t == 1) ? `OTS_RST_SEL1 : `OTS_RST_SEL2;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sel[t] <= RST;
        end else if (do_write && aw_addr == OFF && w_strb[0]
                     && code_ok(new_val[7:0], t == RELAY_IDX)) begin
          sel[t] <= new_val[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sens <= `OTS_RST_SENS;
      fu_fwd <= `OTS_RST_FU_FWD;
      fu_rev <= `OTS_SAME_AS_FWD;
      oc_lvl <= `OTS_RST_LEVEL;
      oc_time <= `OTS_RST_TIME;
      zc_lvl <= `OTS_RST_TIME;
      zc_time <= `OTS_RST_TIME;
      regen_lim <= `OTS_RST_LEVEL;
      therm_lim <= `OTS_RST_LEVEL;
      heat_lim <= `OTS_RST_LEVEL;
      maint_lim <= `OTS_RST_LEVEL;
      remote <= '0;
      start_freq <= `OTS_RST_START;
    end else if (do_write) begin
      case (aw_addr)
        `OTS_OFF_SENS: sens <= upd_val[6:0];
        `OTS_OFF_FU_FWD: fu_fwd <= upd_val[15:0];
        `OTS_OFF_FU_REV: fu_rev <= upd_val[15:0];
        `OTS_OFF_OC_LVL: oc_lvl <= upd_val[15:0];
        `OTS_OFF_OC_TIME: oc_time <= upd_val[15:0];
        `OTS_OFF_ZC_LVL: zc_lvl <= upd_val[15:0];
        `OTS_OFF_ZC_TIME: zc_time <= upd_val[15:0];
        `OTS_OFF_REGEN: regen_lim <= upd_val[15:0];
        `OTS_OFF_THERM: therm_lim <= upd_val[15:0];
        `OTS_OFF_HEAT: heat_lim <= upd_val[15:0];
        `OTS_OFF_MAINT: maint_lim <= upd_val[15:0];
        `OTS_OFF_REMOTE: remote <= upd_val[NUM_TERM-1:0];
        `OTS_OFF_START: start_freq <= upd_val[15:0];
        default: ;
      endcase
    end
  end

  assign fault_clr = do_write && aw_addr == `OTS_OFF_CTRL && w_strb[0]
    && w_data[0];

  ////////////////////////////////////////////////////////////////////////////
  // condition generation
  logic [99:0] cond;
  logic [23:0] diff_x100, band, pct_regen, pct_therm, pct_heat;
  logic [15:0] fdiff, fu_thr, oc_cnt, zc_cnt, pwm_cnt;
  logic [31:0] por_cnt;
  logic por_done, trip, pulse_bit;

  assign fdiff = (out_freq > set_freq) ? out_freq - set_freq
    : set_freq - out_freq;
  assign diff_x100 = 24'(fdiff) * 24'(`OTS_PCT_FULL);
  assign band = 24'(set_freq) * 24'(sens);
  assign fu_thr = (reverse && fu_rev != `OTS_SAME_AS_FWD) ? fu_rev : fu_fwd;
  assign pct_regen = 24'(regen_lim) * 24'(`OTS_PCT_WARN);
  assign pct_therm = 24'(therm_lim) * 24'(`OTS_PCT_WARN);
  assign pct_heat = 24'(heat_lim) * 24'(`OTS_PCT_WARN);

  // detection timers count control cycles and saturate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_cnt <= 16'h0000;
      zc_cnt <= 16'h0000;
    end else begin
      oc_cnt <= (out_current <= oc_lvl) ? 16'h0000 :
        (oc_cnt == 16'hFFFF) ? oc_cnt : oc_cnt + 16'h0001;
      zc_cnt <= (out_current >= zc_lvl) ? 16'h0000 :
        (zc_cnt == 16'hFFFF) ? zc_cnt : zc_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt <= 32'h00000000;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt <= por_cnt + 32'h00000001;
      por_done <= (por_cnt >= 32'(POR_CYCLES - 1));
    end
  end

  // trip holds until software reset; a new fault beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip <= 1'b0;
      thermal_trip <= 1'b0;
    end else begin
      thermal_trip <= thermal_acc >= therm_lim;
      if (fault_event || hw_fault || thermal_trip) begin
        trip <= 1'b1;
      end else if (fault_clr) begin
        trip <= 1'b0;
      end
    end
  end

  // pulse train: current average in one half, maintenance count in the other
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt <= 16'h0000;
    end else begin
      pwm_cnt <= pwm_cnt + 16'h0001;
    end
  end
  assign pulse_bit = pwm_cnt[15] ? (pwm_cnt[7:0] < maint_count[15:8])
    : (pwm_cnt[7:0] < avg_current[15:8]);

  always_comb begin
    cond = '0;
    cond[ots_pkg::OTS_C_ACTIVE] = running && out_freq >= start_freq;
    cond[ots_pkg::OTS_C_SPEED] = running && diff_x100 <= band;
    cond[ots_pkg::OTS_C_OVERLOAD] = stall_active;
    cond[ots_pkg::OTS_C_FREQ] = out_freq >= fu_thr;
    cond[ots_pkg::OTS_C_REGEN] =
      24'(regen_duty) * 24'(`OTS_PCT_FULL) >= pct_regen;
    cond[ots_pkg::OTS_C_THERMAL] =
      24'(thermal_acc) * 24'(`OTS_PCT_FULL) >= pct_therm;
    cond[ots_pkg::OTS_C_READY] = por_done && !trip;
    cond[ots_pkg::OTS_C_OVERCUR] = oc_cnt > oc_time;
    cond[ots_pkg::OTS_C_ZEROCUR] = zc_cnt > zc_time;
    cond[ots_pkg::OTS_C_FB_LOW] = fb_below_low;
    cond[ots_pkg::OTS_C_FB_HIGH] = fb_above_high;
    cond[ots_pkg::OTS_C_PID_FWD] = pid_forward;
    cond[ots_pkg::OTS_C_BRAKE] = brake_seq_en && brake_open;
    cond[ots_pkg::OTS_C_FAN] = fan_fault;
    cond[ots_pkg::OTS_C_HEAT] =
      24'(heatsink_temp) * 24'(`OTS_PCT_FULL) >= pct_heat;
    cond[ots_pkg::OTS_C_PLOSS] = powerloss_decel;
    cond[ots_pkg::OTS_C_PID_ON] = pid_active;
    cond[ots_pkg::OTS_C_RETRY] = retry_active;
    cond[ots_pkg::OTS_C_WEAR] = |life_near_end;
    cond[ots_pkg::OTS_C_HWFAULT] = hw_fault;
    cond[ots_pkg::OTS_C_PULSE] = pulse_bit;
    cond[ots_pkg::OTS_C_MAINT] = maint_count >= maint_lim;
    cond[ots_pkg::OTS_C_MINOR] = fan_fault || comm_warning;
    cond[ots_pkg::OTS_C_TRIP] = trip;
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal drivers
  generate
    for (t = 0; t < NUM_TERM; t++) begin : g_term
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          term_out[t] <= 1'b0;
        end else if (!code_ok(sel[t], t == RELAY_IDX)) begin
          term_out[t] <= 1'b0;
        end else if (code_base(sel[t]) == ots_pkg::OTS_C_REMOTE) begin
          term_out[t] <= remote[t] ^ (sel[t] >= `OTS_NEG_BASE);
        end else begin
          term_out[t] <= cond[code_base(sel[t])]
            ^ (sel[t] >= `OTS_NEG_BASE);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      `OTS_OFF_SEL0: rd_word = {24'h0, sel[0]};
      `OTS_OFF_SEL1: rd_word = {24'h0, sel[1]};
      `OTS_OFF_SEL2: rd_word = {24'h0, sel[2]};
      `OTS_OFF_SENS: rd_word = {25'h0, sens};
      `OTS_OFF_FU_FWD: rd_word = {16'h0, fu_fwd};
      `OTS_OFF_FU_REV: rd_word = {16'h0, fu_rev};
      `OTS_OFF_OC_LVL: rd_word = {16'h0, oc_lvl};
      `OTS_OFF_OC_TIME: rd_word = {16'h0, oc_time};
      `OTS_OFF_ZC_LVL: rd_word = {16'h0, zc_lvl};
      `OTS_OFF_ZC_TIME: rd_word = {16'h0, zc_time};
      `OTS_OFF_REGEN: rd_word = {16'h0, regen_lim};
      `OTS_OFF_THERM: rd_word = {16'h0, therm_lim};
      `OTS_OFF_HEAT: rd_word = {16'h0, heat_lim};
      `OTS_OFF_MAINT: rd_word = {16'h0, maint_lim};
      `OTS_OFF_REMOTE: rd_word = 32'(remote);
      `OTS_OFF_START: rd_word = {16'h0, start_freq};
      `OTS_OFF_CTRL: rd_word = 32'h00000000;
      `OTS_OFF_STATUS: rd_word = {16'(term_out), 13'h0, por_done,
                                 thermal_trip, trip};
      default: rd_word = 32'h00000000;
    endcase
  endfunction : rd_word

  function automatic logic rd_mapped(input logic [7:0] a);
    rd_mapped = a <= `OTS_OFF_STATUS && a[1:0] == 2'h0;
  endfunction : rd_mapped

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `OTS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word(s_axi_araddr);
      s_axi_rresp <= rd_mapped(s_axi_araddr) ? `OTS_RESP_OKAY
        : `OTS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : ots_select
`default_nettype wire

// ===== test/ots_select_assertions.sv
// port-level checks of the output terminal selector
`timescale 1ns/10ps
`default_nettype none
module ots_select_checker #(
  parameter int NUM_TERM = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic stall_active,
  input wire logic fb_above_high,
  input wire logic fan_fault,
  input wire logic brake_seq_en,
  input wire logic brake_open,
  input wire logic powerloss_decel,
  input wire logic [3:0] life_near_end,
  input wire logic hw_fault,
  input wire logic [NUM_TERM-1:0] term_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] aw_q;
  logic [7:0] w_q;
  logic [7:0] sel0;
  logic [7:0] sel0_d;
  logic hold;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 8'h00;
      w_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
    end
  end
  // copy moves on the response, a cycle after the design, so checks
  // only trust it once two samples agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel0 <= 8'h00;
      sel0_d <= 8'h00;
    end else begin
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 &&
          aw_q == 8'h00) sel0 <= w_q;
      sel0_d <= sel0;
    end
  end
  assign hold = (sel0 == sel0_d);
  ////////////////////////////////////////////////////////////////////////
  AST_OVERLOAD: assert property (hold && sel0 == 8'h03 |->
    term_out[0] == $past(stall_active)) else $error("overload term wrong");
  AST_INVERT: assert property (hold && sel0 == 8'h7D |->
    term_out[0] != $past(fan_fault)) else $error("inverted term wrong");
  AST_BRAKE: assert property (hold && sel0 == 8'h14 |->
    term_out[0] == $past(brake_seq_en && brake_open))
    else $error("brake term wrong");
  AST_FB_HIGH: assert property (hold && sel0 == 8'h0F |->
    term_out[0] == $past(fb_above_high)) else $error("feedback term wrong");
  AST_FAN: assert property ((hold && sel0 == 8'h19 && $rose(fan_fault))
    ##1 hold |-> term_out[0]) else $error("fan term missed");
  AST_HWFAULT: assert property ((hold && sel0 == 8'hBF && $fell(hw_fault))
    ##1 hold |-> term_out[0]) else $error("hw fault term wrong");
  AST_WEAR: assert property ((hold && sel0 == 8'h5A && |life_near_end)
    ##1 hold |-> term_out[0]) else $error("wear term missed");
  AST_PLOSS: assert property ((hold && sel0 == 8'h2E && powerloss_decel)
    [*2] ##1 hold |-> term_out[0]) else $error("power loss term missed");
  AST_REFRESH: assert property ((hold && sel0 == 8'h67 &&
    $changed(stall_active)) ##1 hold |-> $changed(term_out[0]))
    else $error("term not refreshed");
endmodule : ots_select_checker
bind ots_select ots_select_checker #(.NUM_TERM(NUM_TERM)) i_chk (.*);
`default_nettype wire

// ===== test/ots_term_monitor.sv
// equipment wired to the output terminals
`timescale 1ns/10ps
`default_nettype none
module ots_term_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] term_out,
  output logic [2:0] seen,
  output int high_cnt
);
  // latched once per cycle; high_cnt lets the bench measure pulse duty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= 3'h0;
      high_cnt <= 0;
    end else begin
      seen <= term_out;
      high_cnt <= high_cnt + int'(term_out[0]);
    end
  end
endmodule : ots_term_monitor
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the output terminal selector
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst_n, inv;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, life_near_end;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, running, reverse, stall_active;
  logic [15:0] out_freq, set_freq, out_current, avg_current;
  logic [15:0] regen_duty, thermal_acc, heatsink_temp, maint_count;
  logic fb_below_low, fb_above_high, pid_forward, pid_active;
  logic retry_active, brake_seq_en, brake_open, fan_fault;
  logic powerloss_decel, hw_fault, comm_warning, fault_event, thermal_trip;
  logic [2:0] term_out, seen;
  int high_cnt, n_mismatch, samples_checked, h;
  localparam logic [7:0] codes [14] = '{8'h03, 8'h67, 8'h0E, 8'h0F, 8'h19,
    8'h7D, 8'h2E, 8'h62, 8'h14, 8'h5A, 8'h10, 8'h2F, 8'h40, 8'hBF};
  localparam int sigs [14] = '{0, 0, 1, 2, 3, 3, 4, 6, 7, 8, 9, 10, 11, 5};
  localparam logic [7:0] tcodes [4] = '{8'h07, 8'h08, 8'h1A, 8'h5F};
  localparam logic [15:0] freqs [5] = '{16'h0384, 16'h0383, 16'h0257,
    16'h02BB, 16'h02BC};
  localparam logic [2:0] fexp [5] = '{3'h3, 3'h2, 3'h0, 3'h0, 3'h2};

  ots_select #(.POR_CYCLES(8)) i_ots_select (.*);
  ots_term_monitor i_ots_term_monitor (.clk(clk), .rst_n(rst_n),
    .term_out(term_out), .seen(seen), .high_cnt(high_cnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (!s_axi_bvalid);
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic lk(input logic [2:0] e, input logic [2:0] m = 3'h7);
    repeat (5) @(posedge clk);
    chk("terms", 32'(seen & m), 32'(e));
  endtask : lk
  task automatic set_sig(input int k, input logic v);
    case (k)
      0: stall_active <= v;
      1: fb_below_low <= v;
      2: fb_above_high <= v;
      3: fan_fault <= v;
      4: powerloss_decel <= v;
      5: hw_fault <= v;
      6: comm_warning <= v;
      7: brake_open <= v;
      8: life_near_end <= {2'h0, v, 1'b0};
      9: pid_forward <= v;
      10: pid_active <= v;
      default: retry_active <= v;
    endcase
  endtask : set_sig
  task automatic set_val(input int k, input logic [15:0] v);
    case (k)
      0: regen_duty <= v;
      1: thermal_acc <= v;
      2: heatsink_temp <= v;
      default: maint_count <= v;
    endcase
  endtask : set_val
  task automatic timed(input logic [7:0] c, input logic [7:0] off,
                       input logic [15:0] lvl, input logic [15:0] cur);
    wr(8'h00, {24'h0, c}, 2'h0);
    wr(off, {16'h0, lvl}, 2'h0);
    wr(off + 8'h04, 32'h6, 2'h0);
    out_current <= cur;
    lk(3'h0, 3'h1);
    repeat (6) @(posedge clk);
    chk("timed", 32'(seen[0]), 32'h1);
    out_current <= lvl;
    lk(3'h0, 3'h1);
  endtask : timed
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, running, reverse} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, life_near_end} = '0;
    {out_freq, set_freq, out_current, avg_current, regen_duty} = '0;
    {thermal_acc, heatsink_temp, maint_count, stall_active} = '0;
    {fb_below_low, fb_above_high, pid_forward, pid_active} = '0;
    {retry_active, brake_open, fan_fault, powerloss_decel} = '0;
    {hw_fault, comm_warning, fault_event, inv} = '0;
    // responses are always accepted at once
    {s_axi_bready, s_axi_rready, brake_seq_en} = '1;
    s_axi_wstrb = 4'hF;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    lk(3'h0);
    rd(8'h04, 32'h4, 2'h0);
    rd(8'h08, 32'h63, 2'h0);
    rd(8'h14, 32'h270F, 2'h0);
    for (int i = 0; i < 14; i++) begin
      wr(8'h00, {24'h0, codes[i]}, 2'h0);
      for (int v = 0; v < 2; v++) begin
        set_sig(sigs[i], v[0]);
        inv = codes[i] > 8'h63;
        lk({2'h0, v[0] ^ inv}, 3'h1);
      end
      set_sig(sigs[i], 1'b0);
    end
    wr(8'h40, 32'h1, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h14, 32'h2BC, 2'h0);
    running <= 1'b1;
    set_freq <= 16'h03E8;
    for (int i = 0; i < 5; i++) begin
      out_freq <= freqs[i];
      reverse <= (i >= 3);
      lk(fexp[i]);
    end
    wr(8'h00, 32'h0, 2'h0);
    out_freq <= 16'h0032;
    lk(3'h1);
    out_freq <= 16'h0031;
    lk(3'h0);
    reverse <= 1'b0;
    for (int i = 0; i < 4; i++) wr(8'h28 + 8'(4 * i), (i == 3) ? 32'h55 : 32'h64, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {24'h0, tcodes[i]}, 2'h0);
      for (int v = 0; v < 2; v++) begin
        set_val(i, v ? 16'h0055 : 16'h0054);
        lk({2'h0, v[0]});
      end
      set_val(i, 16'h0000);
    end
    wr(8'h00, 32'h0B, 2'h0);
    lk(3'h1);
    thermal_acc <= 16'h0064;
    lk(3'h4);
    chk("thermal_trip", 32'(thermal_trip), 32'h1);
    thermal_acc <= 16'h0000;
    lk(3'h4);
    wr(8'h40, 32'h1, 2'h0);
    lk(3'h1);
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    lk(3'h4);
    wr(8'h40, 32'h1, 2'h0);
    timed(8'h0C, 8'h18, 16'h0064, 16'h0065);
    timed(8'h0D, 8'h20, 16'h0032, 16'h0031);
    wr(8'h08, 32'h5D, 2'h2);
    rd(8'h08, 32'h63, 2'h0);
    avg_current <= 16'h8000;
    maint_count <= 16'h8000;
    wr(8'h00, 32'hC1, 2'h0);
    h = high_cnt;
    repeat (256) @(posedge clk);
    h = high_cnt - h;
    chk("pulse duty", 32'(h > 64 && h < 192), 32'h1);
    wr(8'h38, 32'h1, 2'h0);
    wr(8'h00, 32'h60, 2'h0);
    lk(3'h1, 3'h1);
    wr(8'h00, 32'hC4, 2'h0);
    lk(3'h0, 3'h1);
    wr(8'h38, 32'h0, 2'h0);
    lk(3'h1, 3'h1);
    wr(8'h00, 32'h02, 2'h2);
    wr(8'h00, 32'hC8, 2'h2);
    rd(8'h00, 32'hC4, 2'h0);
    wr(8'h44, 32'h0, 2'h2);
    rd(8'h48, 32'h0, 2'h2);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
